/* rtl/owd_cnt_if.sv */
interface owd_cnt_if #(
  parameter int PW = owd_pkg::DIV_W,
  parameter int CW = owd_pkg::TIMEOUT_W
);
  logic run;
  logic osc_edge;
  logic load;
  logic [CW-1:0] load_val;
  logic [PW-1:0] wrap_limit;
  logic [PW-1:0] presc;
  logic [CW-1:0] count;
  logic wrap_tick;

  modport ctrl (output run, osc_edge, load, load_val, wrap_limit, input presc, count, wrap_tick);
  modport core (input run, osc_edge, load, load_val, wrap_limit, output presc, count, wrap_tick);
endinterface

/* rtl/owd_countdown.sv */
module owd_countdown #(
  parameter int PW = owd_pkg::DIV_W,
  parameter int CW = owd_pkg::TIMEOUT_W
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Synchronous chip reset from the reset controller.
  input wire logic sync_clr,
  // Control and counts.
  owd_cnt_if.core cif
);
  typedef struct packed {
    logic [PW-1:0] presc;
    logic [CW-1:0] count;
    logic tick;
  } owd_cd_state_t;

  localparam owd_cd_state_t CD_RST = '{presc: PW'(owd_pkg::DIV_CURRENT_RST),
                                       count: CW'(owd_pkg::TIMEOUT_RST), tick: 1'b0};

  owd_cd_state_t st_reg;
  owd_cd_state_t st_next;

  // Widths below one bit cannot hold a count.
  if (PW < 1 || CW < 1 || PW > 16 || CW > 16) begin : g_bad_width
    $error("owd_countdown: widths must lie between 1 and 16");
  end

  // Prescaler and timeout countdown.
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (cif.run && cif.osc_edge) begin
      if (st_reg.presc == cif.wrap_limit) begin
        st_next.presc = '0;
        st_next.count = st_reg.count - CW'(1);
        st_next.tick = 1'b1;
      end else begin
        st_next.presc = st_reg.presc + PW'(1);
      end
    end
    if (cif.load) begin
      st_next.count = cif.load_val;
    end
    if (sync_clr) begin
      st_next = CD_RST;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= CD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.presc = st_reg.presc;
  assign cif.count = st_reg.count;
  assign cif.wrap_tick = st_reg.tick;

  chk_wrap_clears_decrements: assert property (@(posedge hclk) disable iff (!hresetn)
    cif.run && cif.osc_edge && st_reg.presc == cif.wrap_limit && !cif.load && !sync_clr
    |=> st_reg.presc == '0 && st_reg.count == CW'($past(st_reg.count) - CW'(1)) && cif.wrap_tick)
    else $error("prescaler wrap did not clear and decrement");

  chk_presc_increments: assert property (@(posedge hclk) disable iff (!hresetn)
    cif.run && cif.osc_edge && st_reg.presc != cif.wrap_limit && !sync_clr
    |=> st_reg.presc == PW'($past(st_reg.presc) + PW'(1)))
    else $error("prescaler did not advance on an oscillator edge");

  chk_halt_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    !cif.run && !cif.load && !sync_clr |=> $stable(st_reg.presc) && $stable(st_reg.count))
    else $error("counts moved while counting is halted");

  chk_load_applies: assert property (@(posedge hclk) disable iff (!hresetn)
    cif.load && !sync_clr |=> st_reg.count == $past(cif.load_val))
    else $error("written timeout count not taken");
endmodule

/* rtl/owd_pkg.sv */
package owd_pkg;
  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [15:0] IDX_CONTROL = 16'hF020;
  localparam logic [15:0] IDX_DIV_CURRENT = 16'hF021;
  localparam logic [15:0] IDX_DIV_LIMIT = 16'hF022;
  localparam logic [15:0] IDX_TIMEOUT = 16'hF023;
  localparam logic [15:0] IDX_FIRED = 16'hF024;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hF025;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hF026;

  // Field positions.
  localparam int CTL_COUNT_EN_BIT = 0;
  localparam int CTL_ARM_BIT = 1;
  localparam int FIRED_BIT = 0;
  localparam int IRQ_FIRED_BIT = 0;
  localparam int IRQ_WRAP_BIT = 1;

  // Widths.
  localparam int DIV_W = 16;
  localparam int TIMEOUT_W = 12;
  localparam int IRQ_W = 2;

  // Reset values.
  localparam logic [15:0] DIV_CURRENT_RST = 16'h0000;
  localparam logic [15:0] DIV_LIMIT_RST = 16'hFFFF;
  localparam logic [11:0] TIMEOUT_RST = 12'hFFF;
  localparam logic CTL_COUNT_EN_RST = 1'b0;
  localparam logic CTL_ARM_RST = 1'b0;

  // Bus encodings.
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

/* rtl/owd_top.sv */
// Contract
// - After reset counting and chip-reset arming are both off.
// - Control bit 0 runs the prescaler and countdown; zero halts them.
// - Control bit 1 arms the chip reset on expiry.
// - Read-only prescaler count adds one on each rising oscillator edge.
// - At the wrap limit the prescaler clears and the count decrements together.
// - The wrap limit divides the oscillator by limit plus one.
// - Timeout count resets to 0xFFF; at zero, if armed, the chip resets.
// - Twelve-bit count times sixteen-bit prescaler gives the longest timeout.
// - Fired status bit 0 sets on firing; only power-on reset clears it.
module owd_top #(
  parameter int PW = owd_pkg::DIV_W,
  parameter int CW = owd_pkg::TIMEOUT_W
) (
  // Clock and power-on reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Oscillator and chip reset.
  input wire logic osc_input_pin,
  input wire logic wdt_chip_reset,
  output logic chip_reset_req,
  // Interrupt.
  output logic irq
);
  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic ctl_en;
    logic ctl_arm;
    logic [PW-1:0] wrap_limit;
    logic fired;
    logic rst_req;
    logic [owd_pkg::IRQ_W-1:0] irq_stat;
    logic [owd_pkg::IRQ_W-1:0] irq_mask;
    logic dp_wr;
    logic [15:0] dp_idx;
    logic [31:0] rdata;
  } owd_state_t;

  localparam owd_state_t TOP_RST = '{osc_s1: 1'b0, osc_s2: 1'b0, osc_s3: 1'b0,
    ctl_en: owd_pkg::CTL_COUNT_EN_RST, ctl_arm: owd_pkg::CTL_ARM_RST,
    wrap_limit: PW'(owd_pkg::DIV_LIMIT_RST), fired: 1'b0, rst_req: 1'b0,
    irq_stat: '0, irq_mask: '0, dp_wr: 1'b0, dp_idx: 16'h0000, rdata: 32'h0000_0000};

  owd_state_t st_reg;
  owd_state_t st_next;
  logic addr_ok;
  logic wr_ctl;
  logic wr_limit;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic fire;
  logic [owd_pkg::IRQ_W-1:0] irq_set;

  owd_cnt_if #(.PW(PW), .CW(CW)) cif ();

  // The register map holds sixteen data bits at most.
  // count and prescaler widths
  if (PW < 1 || CW < 1 || PW > 16 || CW > 16) begin : g_bad_width
    $error("owd_top: widths must lie between 1 and 16");
  end

  owd_countdown #(.PW(PW), .CW(CW)) u_countdown (
    .hclk(hclk),
    .hresetn(hresetn),
    .sync_clr(wdt_chip_reset),
    .cif(cif)
  );

  // A word access inside the low address window is taken; all others read zero.
  assign addr_ok = hsel && htrans[1] && hready && hsize == owd_pkg::HSIZE_WORD
                   && haddr[1:0] == 2'b00 && haddr[31:18] == 14'h0000;

  // Write strobes in the data phase.
  assign wr_ctl = st_reg.dp_wr && st_reg.dp_idx == owd_pkg::IDX_CONTROL;
  assign wr_limit = st_reg.dp_wr && st_reg.dp_idx == owd_pkg::IDX_DIV_LIMIT;
  assign wr_irq_stat = st_reg.dp_wr && st_reg.dp_idx == owd_pkg::IDX_IRQ_STATUS;
  assign wr_irq_mask = st_reg.dp_wr && st_reg.dp_idx == owd_pkg::IDX_IRQ_MASK;

  // Counter controls; a timeout write loads the countdown at the data-phase edge.
  assign cif.run = st_reg.ctl_en;
  assign cif.osc_edge = st_reg.osc_s2 && !st_reg.osc_s3;
  assign cif.wrap_limit = st_reg.wrap_limit;
  assign cif.load = st_reg.dp_wr && st_reg.dp_idx == owd_pkg::IDX_TIMEOUT;
  assign cif.load_val = hwdata[CW-1:0];

  assign fire = st_reg.ctl_arm && cif.count == '0;

  // Events that raise interrupt status.
  always_comb begin
    irq_set = '0;
    irq_set[owd_pkg::IRQ_FIRED_BIT] = fire;
    irq_set[owd_pkg::IRQ_WRAP_BIT] = cif.wrap_tick;
  end

  // Next state: synchroniser, registers, events and the bus.
  always_comb begin
    st_next = st_reg;
    st_next.osc_s1 = osc_input_pin;
    st_next.osc_s2 = st_reg.osc_s1;
    st_next.osc_s3 = st_reg.osc_s2;
    if (wr_ctl) begin
      st_next.ctl_en = hwdata[owd_pkg::CTL_COUNT_EN_BIT];
      st_next.ctl_arm = hwdata[owd_pkg::CTL_ARM_BIT];
    end
    if (wr_limit) begin
      st_next.wrap_limit = hwdata[PW-1:0];
    end
    if (wr_irq_mask) begin
      st_next.irq_mask = hwdata[owd_pkg::IRQ_W-1:0];
    end
    // Writing one clears a status bit; a new event in the same cycle wins.
    if (wr_irq_stat) begin
      st_next.irq_stat = st_reg.irq_stat & ~hwdata[owd_pkg::IRQ_W-1:0];
    end
    st_next.irq_stat = st_next.irq_stat | irq_set;
    if (fire) begin
      st_next.rst_req = 1'b1;
    end
    if (fire) begin
      st_next.fired = 1'b1;
    end
    if (wdt_chip_reset) begin
      st_next.ctl_en = owd_pkg::CTL_COUNT_EN_RST;
      st_next.ctl_arm = owd_pkg::CTL_ARM_RST;
      st_next.wrap_limit = PW'(owd_pkg::DIV_LIMIT_RST);
      st_next.rst_req = 1'b0;
      st_next.irq_stat = '0;
      st_next.irq_mask = '0;
    end
    // Address phase capture; read data reflects writes landing this cycle.
    st_next.dp_wr = addr_ok && hwrite;
    st_next.dp_idx = haddr[17:2];
    st_next.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      unique case (haddr[17:2])
        owd_pkg::IDX_CONTROL: begin
          st_next.rdata[owd_pkg::CTL_COUNT_EN_BIT] = st_next.ctl_en;
          st_next.rdata[owd_pkg::CTL_ARM_BIT] = st_next.ctl_arm;
        end
        owd_pkg::IDX_DIV_CURRENT: st_next.rdata = 32'(cif.presc);
        owd_pkg::IDX_DIV_LIMIT: st_next.rdata = 32'(st_next.wrap_limit);
        owd_pkg::IDX_TIMEOUT: st_next.rdata = cif.load ? 32'(cif.load_val) : 32'(cif.count);
        owd_pkg::IDX_FIRED: st_next.rdata[owd_pkg::FIRED_BIT] = st_next.fired;
        owd_pkg::IDX_IRQ_STATUS: st_next.rdata = 32'(st_next.irq_stat);
        owd_pkg::IDX_IRQ_MASK: st_next.rdata = 32'(st_next.irq_mask);
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; only power-on reset clears the fired flag.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= TOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bus answers without wait states and always with OKAY.
  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = owd_pkg::HRESP_OKAY;
  assign chip_reset_req = st_reg.rst_req;
  assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

  chk_fire_requests_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.ctl_arm && cif.count == '0 && !wdt_chip_reset |=> chip_reset_req && st_reg.fired)
    else $error("armed expiry did not request chip reset");

  chk_unarmed_no_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_reg.ctl_arm && !chip_reset_req |=> !chip_reset_req)
    else $error("chip reset requested while disarmed");

  chk_fired_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    st_reg.fired |=> st_reg.fired [*2])
    else $error("fired flag cleared without power-on reset");

  chk_chip_reset_disarms: assert property (@(posedge hclk) disable iff (!hresetn)
    wdt_chip_reset |=> !st_reg.ctl_en && !st_reg.ctl_arm && !chip_reset_req)
    else $error("chip reset left the watchdog running");

  chk_ctl_write_steers: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctl && !wdt_chip_reset |=> cif.run == $past(hwdata[owd_pkg::CTL_COUNT_EN_BIT]))
    else $error("control write did not steer counting");

  chk_irq_follows_event: assert property (@(posedge hclk) disable iff (!hresetn)
    cif.wrap_tick && st_reg.irq_mask[owd_pkg::IRQ_WRAP_BIT] && !wdt_chip_reset && !wr_irq_mask |=> irq)
    else $error("masked-in wrap event did not raise irq");

  chk_read_timeout: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[17:2] == owd_pkg::IDX_TIMEOUT && !cif.load
    |=> hrdata == 32'($past(cif.count)))
    else $error("timeout count read back wrong");

  cov_armed_fire: cover property (@(posedge hclk) disable iff (!hresetn) $rose(chip_reset_req));
  cov_debug_wrap: cover property (@(posedge hclk) disable iff (!hresetn) cif.wrap_tick && !st_reg.ctl_arm);
  cov_refresh_count: cover property (@(posedge hclk) disable iff (!hresetn) cif.load && st_reg.ctl_en);
  cov_irq_raised: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule

/* verification/owd_top_tb.sv */
module owd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, osc, wcr, chip_rst, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int num_errors, n_checks, seed, mpresc, mcnt, mlim, men, n;

  owd_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_input_pin(osc), .wdt_chip_reset(wcr),
    .chip_reset_req(chip_rst), .irq(irq));

  // The single slave drives the bus ready.
  assign hready = hreadyout;

  // Free-running 10 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Prints the counts and the verdict, then stops.
  task results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // One phase of a transfer; ready and read data are taken at the rising edge, before the flops update.
  task phase;
    int k;
    logic ok;
    k = 0;
    ok = 1'b0;
    while (!ok) begin
      @(posedge hclk);
      ok = (hready === 1'b1);
      rd = hrdata;
      k++;
      if (k > 50) begin
        num_errors++;
        results();
      end
    end
  endtask

  // Single word transfer; entered just after a rising edge.
  task bus(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= owd_pkg::HSIZE_WORD;
    phase();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    phase();
  endtask

  task rdc(input logic [15:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h00000000);
    chk(rd, exp);
    chk({31'h0, hresp}, {31'h0, owd_pkg::HRESP_OKAY});
  endtask

  // Looks at the two level outputs once they have settled.
  task look(input logic e_rst, input logic e_irq);
    @(negedge hclk);
    chk({31'h0, chip_rst}, {31'h0, e_rst});
    chk({31'h0, irq}, {31'h0, e_irq});
    @(posedge hclk);
  endtask

  // Oscillator edges, each level held three clocks; the model follows every rising edge.
  task osc_edges(input int cnt);
    repeat (cnt) begin
      osc <= 1'b1;
      repeat (3) @(posedge hclk);
      osc <= 1'b0;
      repeat (3) @(posedge hclk);
      if (men != 0) begin
        if (mpresc == mlim) begin
          mpresc = 0;
          mcnt = (mcnt + 4095) % 4096;
        end else mpresc++;
      end
    end
    repeat (4) @(posedge hclk);
  endtask

  task power_on;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    mpresc = 0;
    mcnt = 4095;
    mlim = 65535;
    men = 0;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    results();
  end

  initial begin
    seed = 85;
    {hresetn, hsel, hwrite, osc, wcr} = 5'h00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    num_errors = 0;
    n_checks = 0;
    power_on();
    rdc(owd_pkg::IDX_CONTROL, 32'h00000000);
    rdc(owd_pkg::IDX_DIV_LIMIT, 32'h0000FFFF);
    rdc(owd_pkg::IDX_TIMEOUT, 32'h00000FFF);
    rdc(owd_pkg::IDX_FIRED, 32'h00000000);
    rdc(owd_pkg::IDX_IRQ_STATUS, 32'h00000000);
    rdc(owd_pkg::IDX_IRQ_MASK, 32'h00000000);
    rdc(16'hF027, 32'h00000000);
    bus(owd_pkg::IDX_DIV_CURRENT, 1'b1, 32'h00000005);
    osc_edges(3);
    rdc(owd_pkg::IDX_DIV_CURRENT, 32'h00000000);
    $display("test reset and halt done");
    for (int i = 0; i < 3; i++) begin
      mlim = mpresc + ($unsigned($random(seed)) % 4);
      bus(owd_pkg::IDX_DIV_LIMIT, 1'b1, mlim);
      bus(owd_pkg::IDX_CONTROL, 1'b1, 32'h00000001);
      men = 1;
      n = 2 + ($unsigned($random(seed)) % 10);
      osc_edges(n);
      rdc(owd_pkg::IDX_DIV_CURRENT, mpresc);
      rdc(owd_pkg::IDX_TIMEOUT, mcnt);
      look(1'b0, 1'b0);
    end
    $display("test prescaler done");
    bus(owd_pkg::IDX_TIMEOUT, 1'b1, 32'h00000002);
    mcnt = 2;
    rdc(owd_pkg::IDX_TIMEOUT, 32'h00000002);
    bus(owd_pkg::IDX_IRQ_MASK, 1'b1, 32'h00000001);
    osc_edges(mlim - mpresc + 1 + mlim + 1);
    rdc(owd_pkg::IDX_TIMEOUT, mcnt);
    look(1'b0, 1'b0);
    bus(owd_pkg::IDX_CONTROL, 1'b1, 32'h00000003);
    repeat (2) @(posedge hclk);
    look(1'b1, 1'b1);
    rdc(owd_pkg::IDX_FIRED, 32'h00000001);
    bus(owd_pkg::IDX_IRQ_MASK, 1'b1, 32'h00000000);
    look(1'b1, 1'b0);
    $display("test fire done");
    wcr <= 1'b1;
    @(posedge hclk);
    wcr <= 1'b0;
    @(posedge hclk);
    look(1'b0, 1'b0);
    rdc(owd_pkg::IDX_FIRED, 32'h00000001);
    rdc(owd_pkg::IDX_CONTROL, 32'h00000000);
    rdc(owd_pkg::IDX_TIMEOUT, 32'h00000FFF);
    $display("test chip reset done");
    bus(owd_pkg::IDX_DIV_LIMIT, 1'b1, 32'h00000000);
    bus(owd_pkg::IDX_IRQ_MASK, 1'b1, 32'h00000002);
    bus(owd_pkg::IDX_CONTROL, 1'b1, 32'h00000001);
    {mpresc, mcnt, mlim, men} = {32'd0, 32'd4095, 32'd0, 32'd1};
    osc_edges(1);
    look(1'b0, 1'b1);
    rdc(owd_pkg::IDX_TIMEOUT, mcnt);
    bus(owd_pkg::IDX_IRQ_STATUS, 1'b1, 32'h00000002);
    look(1'b0, 1'b0);
    bus(owd_pkg::IDX_IRQ_MASK, 1'b1, 32'h00000000);
    osc_edges(1);
    look(1'b0, 1'b0);
    rdc(owd_pkg::IDX_IRQ_STATUS, 32'h00000002);
    $display("test interrupt done");
    power_on();
    rdc(owd_pkg::IDX_FIRED, 32'h00000000);
    rdc(owd_pkg::IDX_DIV_CURRENT, 32'h00000000);
    $display("test power on done");
    results();
  end
endmodule
